// *** bench/slm_lane_mapper_asserts.sv ***
// Concurrent checks bound to the lane mapper ports
`timescale 1ns/1ps
module slm_lane_mapper_chk (
  input logic         aclk,
  input logic         aresetn,
  input logic         s_axi_awvalid,
  input logic         s_axi_awready,
  input logic         s_axi_wvalid,
  input logic         s_axi_wready,
  input logic [1:0]   s_axi_bresp,
  input logic         s_axi_bvalid,
  input logic         s_axi_bready,
  input logic         s_axi_arvalid,
  input logic         s_axi_arready,
  input logic [31:0]  s_axi_rdata,
  input logic         s_axi_rvalid,
  input logic         s_axi_rready,
  input logic [287:0] sample_data,
  input logic         sample_valid,
  input logic         sleep_input,
  input logic [191:0] lane_data,
  input logic         lane_valid,
  input logic [7:0]   lane_drive_en,
  input logic         lane_bypass
);
  logic [7:0]  quiet_ok;
  logic [15:0] pad_ok;
  always_comb begin
    for (int l = 0; l < 8; l++) begin
      quiet_ok[l]     = lane_drive_en[l] || (lane_data[l*24 +: 24] == 24'h0);
      pad_ok[2*l]     = lane_data[l*24 +: 3] == 3'h0;
      pad_ok[2*l + 1] = lane_data[l*24 + 12 +: 3] == 3'h0;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  chk_sleep_off: assert property (sleep_input [*3] |=> lane_drive_en == 8'h00)
    else $error("drivers on in sleep");
  chk_quiet_lane: assert property (&quiet_ok) else $error("idle lane not zero");
  chk_lane_set: assert property (
    lane_drive_en inside {8'h00, 8'h03, 8'h0f, 8'h30, 8'hf0, 8'hff}) else $error("bad lane set");
  chk_pad_zero: assert property (lane_valid && !lane_bypass |-> &pad_ok)
    else $error("pad bits not zero");
  // Lane 0 slot 0 is channel A sample 0 in both layouts, so no layout knowledge needed
  chk_data_pass: assert property (lane_valid && !lane_bypass && lane_drive_en[0]
    |-> lane_data[23:12] == {$past(sample_data[8:0]), 3'h0}) else $error("sample not passed");
  chk_valid_src: assert property (lane_valid && !lane_bypass |-> $past(sample_valid))
    else $error("valid without sample");
endmodule
bind slm_lane_mapper slm_lane_mapper_chk i_slm_lane_mapper_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_data,
  .sample_valid, .sleep_input, .lane_data, .lane_valid, .lane_drive_en, .lane_bypass);

// *** bench/slm_link_rx_model.sv ***
// Link receiver model: per-lane self-syncing PRBS checker
`timescale 1ns/1ps
module slm_link_rx_model (
  input  logic         aclk,
  input  logic [191:0] lane_data,
  input  logic         lane_valid,
  input  logic [7:0]   lane_drive_en,
  input  logic         lane_bypass,
  input  int           tap_a,
  input  int           tap_b,
  output int           n_bad,
  output int           n_seen
);
  logic [30:0] hist [8];
  int          fill [8];
  logic        bit_v;
  initial begin
    n_bad = 0;
    n_seen = 0;
    foreach (fill[i]) fill[i] = 0;
  end
  ////////////////////////////////////////////////////////////
  // No start phase assumed: lock on the first tap_b bits seen
  // A valid gap drops lock, so stale words after sleep are discarded
  always @(posedge aclk) begin
    for (int l = 0; l < 8; l++) begin
      if (!lane_valid || !lane_bypass || !lane_drive_en[l]) begin
        fill[l] = 0;
      end else begin
        for (int b = 23; b >= 0; b--) begin
          bit_v = lane_data[l*24 + b];
          if (fill[l] >= tap_b) begin
            n_seen++;
            if (bit_v !== (hist[l][tap_a-1] ^ hist[l][tap_b-1])) n_bad++;
          end
          hist[l] = {hist[l][29:0], bit_v};
          fill[l]++;
        end
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the lane mapper
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic         s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic         s_axi_rvalid, sample_valid, sleep_input, lane_valid, lane_bypass;
  logic         sync_header_fec;
  logic [7:0]   s_axi_awaddr, s_axi_araddr, lane_drive_en;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic [287:0] sample_data;
  logic [191:0] lane_data;
  int           n_errors, cmp_count, cyc, tap_a, tap_b, n_bad, n_seen;

  slm_lane_mapper i_slm_lane_mapper (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_data, .sample_valid,
    .sleep_input, .lane_data, .lane_valid, .lane_drive_en, .lane_bypass, .sync_header_fec);
  slm_link_rx_model i_slm_link_rx_model (.aclk, .lane_data, .lane_valid, .lane_drive_en,
    .lane_bypass, .tap_a, .tap_b, .n_bad, .n_seen);
  ////////////////////////////////////////////////////////////
  function automatic logic [8:0] smp(int c, int s);
    return 9'(9'h100 | (c * 32 + s));
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic pend;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      pend = (s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (pend);
    // Late ready makes the slave hold its answer for a while
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_lanes(input bit dual, input int base, input logic [7:0] en);
    int          n, c, s;
    logic [23:0] ex;
    for (int p = 0; p < 8; p++) begin
      n = p - base;
      c = dual ? n / 4 : n / 2;
      s = dual ? n % 4 : n % 2;
      ex = en[p] ? {smp(c, s), 3'h0, smp(c, s + (dual ? 4 : 2)), 3'h0} : 24'h0;
      `CHK("lane word", ex, lane_data[p*24 +: 24])
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(8'h00);
    `CHK("ctrl", 32'h0, rd)
    axi_rd(8'h04);
    `CHK("status", 32'hff, rd)
    axi_rd(8'h08);
    `CHK("unmapped", 34'h2_0000_0000, ({resp, rd}))
    axi_wr(8'h04, 32'h0);
    `CHK("ro write", slm_pkg::AXI_SLVERR, resp)
    $display("t_regs done");
  endtask
  task automatic t_map();
    logic [7:0] cf [8] = '{8'h00, 8'h04, 8'h01, 8'h09, 8'h0a, 8'h08, 8'h0d, 8'h0b};
    logic [7:0] ef [8] = '{8'hff, 8'hff, 8'h0f, 8'hf0, 8'h30, 8'hff, 8'hf0, 8'h00};
    for (int i = 0; i < 8; i++) begin
      axi_wr(8'h00, {24'h0, cf[i]});
      repeat (3) @(posedge aclk);
      `CHK("drive en", ef[i], lane_drive_en)
      chk_lanes(cf[i][2], ef[i][0] ? 0 : 4, ef[i]);
      axi_rd(8'h04);
      `CHK("status", ({21'h0, !ef[i][0], 2'h0, ef[i]}), rd)
    end
    $display("t_map done");
  endtask
  task automatic t_fec();
    axi_wr(8'h00, 32'h10);
    repeat (2) @(posedge aclk);
    `CHK("fec", 1'b1, sync_header_fec)
    axi_wr(8'h00, 32'h0);
    sample_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("crc12", 1'b0, sync_header_fec)
    `CHK("no sample", 1'b0, lane_valid)
    sample_valid <= 1'b1;
    $display("t_fec done");
  endtask
  task automatic t_sleep();
    axi_wr(8'h00, 32'h01);
    sleep_input <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("sleep drive", 8'h00, lane_drive_en)
    `CHK("sleep valid", 1'b0, lane_valid)
    axi_rd(8'h00);
    `CHK("kept ctrl", 32'h01, rd)
    sleep_input <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("wake drive", 8'h0f, lane_drive_en)
    axi_wr(8'h00, 32'h21);
    repeat (2) @(posedge aclk);
    `CHK("bit sleep", 8'h00, lane_drive_en)
    axi_rd(8'h04);
    `CHK("asleep", 1'b1, rd[8])
    $display("t_sleep done");
  endtask
  task automatic t_prbs();
    int ta [5] = '{6, 5, 14, 18, 28};
    int tz [5] = '{7, 9, 15, 23, 31};
    int seen0;
    for (int k = 0; k < 5; k++) begin
      // Pattern changed only with test traffic stopped
      axi_wr(8'h00, 32'h01);
      repeat (2) @(posedge aclk);
      tap_a = ta[k];
      tap_b = tz[k];
      seen0 = n_seen;
      axi_wr(8'h00, {21'h0, 3'(k + 1), 8'h01});
      repeat (8) @(posedge aclk);
      `CHK("bypass", 1'b1, lane_bypass)
      `CHK("prbs drive", 8'h0f, lane_drive_en)
      `CHK("phase", 1'b1, lane_data[23:0] !== lane_data[47:24])
      `CHK("prbs seen", 1'b1, n_seen > seen0)
    end
    `CHK("prbs bad", 0, n_bad)
    axi_rd(8'h04);
    `CHK("prbs stat", 1'b1, rd[9])
    axi_wr(8'h00, 32'h601);
    repeat (3) @(posedge aclk);
    `CHK("no test", 1'b0, lane_bypass)
    chk_lanes(1'b0, 0, 8'h0f);
    $display("t_prbs done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("mismatch timeout expected done seen hang");
      close_out();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sleep_input} = '0;
    s_axi_wstrb = 4'hf;
    sample_valid = 1'b1;
    tap_a = 6;
    tap_b = 7;
    for (int c = 0; c < 4; c++) for (int s = 0; s < 8; s++) sample_data[(c*8+s)*9 +: 9] = smp(c, s);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_map();
    t_fec();
    t_sleep();
    t_prbs();
    close_out();
  end
endmodule

// *** design/slm_lane_mapper.sv ***
// Lane mapper top: register slave, sample mapping, lane set, sleep and test patterns
`timescale 1ns/1ps
module slm_lane_mapper (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                      s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [7:0]                      s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // Sample input, channel c sample s at bits (c*8+s)*9
  input  wire logic [slm_pkg::SMP_BUS_W-1:0]   sample_data,
  input  wire logic                            sample_valid,
  // Sleep pin from outside the clock domain
  input  wire logic                            sleep_input,
  // Serializer side
  output logic [slm_pkg::NUM_LANES*slm_pkg::LANE_W-1:0] lane_data,
  output logic                                 lane_valid,
  output logic [slm_pkg::NUM_LANES-1:0]        lane_drive_en,
  output logic                                 lane_bypass,
  output logic                                 sync_header_fec
);
  localparam int NL = slm_pkg::NUM_LANES;
  localparam int LW = slm_pkg::LANE_W;

  //////////////////////////////////////////////////////////////////////////////
  // Register slave
  logic [31:0] ctrl_reg;
  logic [31:0] status_word;
  logic        aw_have_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] wr_merged;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_have_reg && w_have_reg;
  assign wr_hit        = (aw_addr_reg[7:2] == slm_pkg::CTRL_OFS[7:2]);

  always_comb begin
    wr_merged = ctrl_reg;
    for (int b = 0; b < 4; b++) begin
      if (w_strb_reg[b]) begin
        wr_merged[b*8 +: 8] = w_data_reg[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // Settings are held only by reset, never by sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= slm_pkg::CTRL_RST;
    end else if (wr_fire && wr_hit) begin
      ctrl_reg <= wr_merged & slm_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= slm_pkg::AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? slm_pkg::AXI_OKAY : slm_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= slm_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[7:2] == slm_pkg::CTRL_OFS[7:2]) begin
        s_axi_rdata <= ctrl_reg;
        s_axi_rresp <= slm_pkg::AXI_OKAY;
      end else if (s_axi_araddr[7:2] == slm_pkg::STATUS_OFS[7:2]) begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= slm_pkg::AXI_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= slm_pkg::AXI_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control decode
  logic [1:0] lane_mode_select;
  logic       dual_layout;
  logic       lane_set_select;
  logic [2:0] test_pattern_select;
  logic       alt_active;
  logic       prbs_on;
  logic       asleep;
  logic       sleep_meta_reg;
  logic       sleep_sync_reg;
  logic [NL-1:0] lane_active;

  assign lane_mode_select    = ctrl_reg[slm_pkg::CTRL_CNT_LSB +: 2];
  assign dual_layout         = ctrl_reg[slm_pkg::CTRL_FMT_BIT];
  assign lane_set_select     = ctrl_reg[slm_pkg::CTRL_ALT_BIT];
  assign test_pattern_select = ctrl_reg[slm_pkg::CTRL_TP_LSB +: 3];

  // Alternate set only with four lanes or fewer; eight lanes already use both sets
  assign alt_active = lane_set_select && (lane_mode_select != slm_pkg::CNT_8);

  always_comb begin
    unique case (test_pattern_select)
      slm_pkg::SLM_TP_PRBS7,
      slm_pkg::SLM_TP_PRBS9,
      slm_pkg::SLM_TP_PRBS15,
      slm_pkg::SLM_TP_PRBS23,
      slm_pkg::SLM_TP_PRBS31: prbs_on = 1'b1;
      default:                prbs_on = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= sleep_input;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // Receiver must relink and flush stale samples after wake; nothing here holds off data
  assign asleep = sleep_sync_reg || ctrl_reg[slm_pkg::CTRL_SLP_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Lane mapping and enables
  logic [NL*LW-1:0] mapped_word;
  logic [NL*LW-1:0] prbs_word;
  logic [2:0]       tp_prev_reg;
  logic             prbs_restart;
  logic             prbs_fresh_reg;

  // Restart on any change of selection; the link is expected down meanwhile
  assign prbs_restart = (test_pattern_select != tp_prev_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tp_prev_reg <= slm_pkg::SLM_TP_NONE;
    end else begin
      tp_prev_reg <= test_pattern_select;
    end
  end

  // Generator word is still the cleared one the cycle after a restart; keep it unmarked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prbs_fresh_reg <= 1'b0;
    end else begin
      prbs_fresh_reg <= prbs_restart;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lane
      localparam int LOG_L = g % 4;
      localparam int QA_CH = g / 2;
      localparam int QA_S0 = g % 2;
      localparam int DU_CH = g / 4;
      localparam int DU_S0 = g % 4;
      logic [3:0]                  logical;
      logic [1:0]                  ch_q;
      logic [2:0]                  s0_q;
      logic [slm_pkg::SMP_W-1:0]   smp0;
      logic [slm_pkg::SMP_W-1:0]   smp1;
      logic                        in_set;

      // Lane set 0 maps logical lane n to n, set 1 moves it up by four
      always_comb begin
        if (alt_active) begin
          in_set  = (g >= 4);
          logical = 4'(LOG_L);
        end else begin
          in_set  = (g < 4) || (lane_mode_select == slm_pkg::CNT_8);
          logical = 4'(g);
        end
      end

      // Count follows lane mode only, whatever test is running
      always_comb begin
        unique case (lane_mode_select)
          slm_pkg::CNT_8: lane_active[g] = in_set;
          slm_pkg::CNT_4: lane_active[g] = in_set && (logical < 4'h4);
          slm_pkg::CNT_2: lane_active[g] = in_set && (logical < 4'h2);
          default:        lane_active[g] = 1'b0;
        endcase
      end

      // Channel and first sample of the logical lane for each layout
      always_comb begin
        if (dual_layout) begin
          ch_q = (logical < 4'h4) ? 2'h0 : 2'h1;
          s0_q = 3'(logical % 4);
          smp0 = sample_data[(32'(ch_q) * 8 + 32'(s0_q)) * slm_pkg::SMP_W +: slm_pkg::SMP_W];
          smp1 = sample_data[(32'(ch_q) * 8 + 32'(s0_q) + 4) * slm_pkg::SMP_W +: slm_pkg::SMP_W];
        end else begin
          ch_q = 2'(logical / 2);
          s0_q = 3'(logical % 2);
          smp0 = sample_data[(32'(ch_q) * 8 + 32'(s0_q)) * slm_pkg::SMP_W +: slm_pkg::SMP_W];
          smp1 = sample_data[(32'(ch_q) * 8 + 32'(s0_q) + 2) * slm_pkg::SMP_W +: slm_pkg::SMP_W];
        end
      end

      // Slot 0 occupies the upper half of the lane word
      assign mapped_word[g*LW +: LW] = {smp0, {slm_pkg::PAD_W{1'b0}},
                                        smp1, {slm_pkg::PAD_W{1'b0}}};

      slm_prbs_gen u_prbs (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .restart   (prbs_restart),
        .run       (prbs_on),
        .order_sel (test_pattern_select),
        .seed      ({slm_pkg::SEED_HI, 7'(g + 1)}),
        .word      (prbs_word[g*LW +: LW])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Output stage
  logic [NL-1:0] drive_next;

  // Inactive set and sleep both force drivers off
  assign drive_next = asleep ? '0 : lane_active;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_drive_en <= '0;
    end else begin
      lane_drive_en <= drive_next;
    end
  end

  // PRBS words bypass framing; idle lanes carry zero so nothing leaks out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_data  <= '0;
      lane_valid <= 1'b0;
    end else if (prbs_on) begin
      for (int l = 0; l < NL; l++) begin
        lane_data[l*LW +: LW] <= drive_next[l] ? prbs_word[l*LW +: LW] : '0;
      end
      lane_valid <= !asleep && !prbs_restart && !prbs_fresh_reg;
    end else begin
      for (int l = 0; l < NL; l++) begin
        lane_data[l*LW +: LW] <= drive_next[l] ? mapped_word[l*LW +: LW] : '0;
      end
      lane_valid <= sample_valid && !asleep;
    end
  end

  // Only the CRC-12 and FEC choices exist for the sync header
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_header_fec <= 1'b0;
      lane_bypass     <= 1'b0;
    end else begin
      sync_header_fec <= ctrl_reg[slm_pkg::CTRL_FEC_BIT];
      lane_bypass     <= prbs_on;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[slm_pkg::STAT_EN_LSB +: NL] = lane_drive_en;
    status_word[slm_pkg::STAT_SLP_BIT]      = asleep;
    status_word[slm_pkg::STAT_PRBS_BIT]     = prbs_on;
    status_word[slm_pkg::STAT_ALT_BIT]      = alt_active;
  end
endmodule

// *** design/slm_pkg.sv ***
// Shared constants for the lane mapper and its test pattern generators
// Summary of operation
// - Quad layout: two padded samples per lane
// - Dual layout: four lanes per channel, slots
// - Sync header error check is CRC-12 by default
// - Sync header may carry FEC instead
// - Lane redundancy only for four lanes or fewer
// - Lane set 0 uses lanes 3..0, 1 uses 7..4
// - Unselected lane set stays inactive
// - Sleep input disables all lane drivers
// - Control bit can also force sleep
// - Settings survive sleep unchanged
// - Test pattern chosen by select field
// - Test patterns never change powered lanes
// - PRBS bypasses transport, link, scrambling, encoding
// - PRBS7 taps six and seven
// - PRBS9 taps five and nine
// - PRBS15 taps fourteen and fifteen
// - PRBS23 taps eighteen and twenty-three
// - PRBS31 taps twenty-eight and thirty-one
// - Each lane PRBS starts at own phase
package slm_pkg;
  localparam int NUM_LANES  = 8;
  localparam int NUM_CH     = 4;
  localparam int SMP_PER_CH = 8;
  localparam int SMP_W      = 9;
  localparam int PAD_W      = 3;
  localparam int SLOT_W     = SMP_W + PAD_W;
  localparam int LANE_W     = 2 * SLOT_W;
  localparam int SMP_BUS_W  = NUM_CH * SMP_PER_CH * SMP_W;
  localparam int PRBS_W     = 31;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control fields
  localparam int CTRL_CNT_LSB  = 0;
  localparam int CTRL_FMT_BIT  = 2;
  localparam int CTRL_ALT_BIT  = 3;
  localparam int CTRL_FEC_BIT  = 4;
  localparam int CTRL_SLP_BIT  = 5;
  localparam int CTRL_TP_LSB   = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_073f;

  // Status fields
  localparam int STAT_EN_LSB   = 0;
  localparam int STAT_SLP_BIT  = 8;
  localparam int STAT_PRBS_BIT = 9;
  localparam int STAT_ALT_BIT  = 10;

  // Lane count codes
  localparam logic [1:0] CNT_8 = 2'h0;
  localparam logic [1:0] CNT_4 = 2'h1;
  localparam logic [1:0] CNT_2 = 2'h2;

  typedef enum logic [2:0] {
    SLM_TP_NONE   = 3'h0,
    SLM_TP_PRBS7  = 3'h1,
    SLM_TP_PRBS9  = 3'h2,
    SLM_TP_PRBS15 = 3'h3,
    SLM_TP_PRBS23 = 3'h4,
    SLM_TP_PRBS31 = 3'h5
  } slm_tp_e;

  // Low seed bits come from the lane number, so every order differs per lane
  localparam logic [23:0] SEED_HI = 24'h5a_c3_96;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// *** design/slm_prbs_gen.sv ***
// One lane of PRBS generation, one lane word per clock
`timescale 1ns/1ps
module slm_prbs_gen (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        restart,
  input  wire logic                        run,
  input  wire logic [2:0]                  order_sel,
  input  wire logic [slm_pkg::PRBS_W-1:0]  seed,
  output logic      [slm_pkg::LANE_W-1:0]  word
);
  logic [slm_pkg::PRBS_W-1:0] state_reg;
  logic [slm_pkg::PRBS_W-1:0] state_next;
  logic [slm_pkg::LANE_W-1:0] word_next;
  logic [4:0]                 tap_a;
  logic [4:0]                 tap_b;

  always_comb begin
    unique case (order_sel)
      slm_pkg::SLM_TP_PRBS7: begin
        tap_a = 5'h05;
        tap_b = 5'h06;
      end
      slm_pkg::SLM_TP_PRBS9: begin
        tap_a = 5'h04;
        tap_b = 5'h08;
      end
      slm_pkg::SLM_TP_PRBS15: begin
        tap_a = 5'h0d;
        tap_b = 5'h0e;
      end
      slm_pkg::SLM_TP_PRBS23: begin
        tap_a = 5'h11;
        tap_b = 5'h16;
      end
      default: begin
        tap_a = 5'h1b;
        tap_b = 5'h1e;
      end
    endcase
  end

  // Bit 0 of the state is the most recent bit sent; first bit goes out at the word MSB
  always_comb begin
    state_next = state_reg;
    word_next  = '0;
    for (int i = 0; i < slm_pkg::LANE_W; i++) begin
      word_next[slm_pkg::LANE_W-1-i] = state_next[tap_a] ^ state_next[tap_b];
      state_next = {state_next[slm_pkg::PRBS_W-2:0], word_next[slm_pkg::LANE_W-1-i]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '1;
    end else if (restart) begin
      state_reg <= seed;
    end else if (run) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || restart) begin
      word <= '0;
    end else begin
      word <= word_next;
    end
  end
endmodule
